/* rtl/apwm_timer.sv */
// Dual-slope PWM timer core with oscillator-paced write, read and flag paths
`timescale 1ns/10ps
`default_nettype none
module apwm_timer
  import apwm_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       clk_en,
  input  wire logic       async_clock_sel,
  input  wire logic       osc_input_pin,
  input  wire logic       power_down,
  input  wire logic [4:0] reg_wr_strobe,
  input  wire logic [7:0] reg_wr_data,
  input  wire logic       ovf_clear,
  input  wire logic       cmp_clear_a,
  input  wire logic       cmp_clear_b,
  input  wire logic       port_data_a,
  input  wire logic       port_data_b,
  input  wire logic       port_dir_out_a,
  input  wire logic       port_dir_out_b,
  output logic [7:0]      counter_read_ff,
  output logic [4:0]      update_busy_ff,
  output logic            overflow_flag_ff,
  output logic            compare_flag_a_ff,
  output logic            compare_flag_b_ff,
  output logic            wake_ff,
  output logic            compare_output_a,
  output logic            compare_output_b,
  output logic            pin_level_a,
  output logic            pin_level_b,
  output logic            pin_oe_n_a,
  output logic            pin_oe_n_b
);
  // Oscillator sampling and prescaler
  logic       osc_q_ff;
  logic       osc_prev_ff;
  logic [9:0] pre_ff;
  logic [9:0] nxt_pre;
  logic       osc_rise;
  logic       src_en;
  logic       tick;

  // Effective registers and write staging
  logic [7:0] cnt_ff;
  logic [7:0] cmp_a_ff;
  logic [7:0] cmp_b_ff;
  logic [7:0] ctrl_a_ff;
  logic [7:0] ctrl_b_ff;
  logic       cnt_up_ff;
  logic [7:0] temp_ff     [NUM_REGS];
  logic [1:0] edges_ff    [NUM_REGS];
  logic [7:0] nxt_temp    [NUM_REGS];
  logic [1:0] nxt_edges   [NUM_REGS];
  logic [4:0] nxt_busy;
  logic [4:0] load;
  logic [7:0] load_val    [NUM_REGS];
  logic [7:0] nxt_cnt;
  logic [7:0] nxt_cmp_a;
  logic [7:0] nxt_cmp_b;
  logic [7:0] nxt_ctrl_a;
  logic [7:0] nxt_ctrl_b;
  logic       nxt_cnt_up;

  // Decoded control and events
  logic [2:0] mode;
  logic [2:0] clk_sel;
  logic       pc_mode;
  logic [7:0] top_val;
  logic       evt;
  logic       at_top;
  logic       at_bot;
  logic       inhibit_a;
  logic       inhibit_b;
  logic [2:0] raw_flag;
  logic [2:0] pipe_ff     [FLAG_PIPE];
  logic [2:0] nxt_pipe    [FLAG_PIPE];
  logic [2:0] set_flag;
  logic       nxt_ovf;
  logic       nxt_cfa;
  logic       nxt_cfb;
  logic       wake_arm_ff;
  logic       nxt_wake_arm;
  logic       nxt_wake;
  logic [7:0] nxt_read;

  always_comb begin
    osc_rise = osc_q_ff & ~osc_prev_ff & ~power_down;
    src_en   = async_clock_sel ? osc_rise : 1'b1;
    clk_sel  = ctrl_b_ff[CB_CS_LSB +: 3];
    nxt_pre  = src_en ? pre_ff + 10'h001 : pre_ff;
    case (clk_sel)
      CS_STOP:    tick = 1'b0;
      CS_DIV1:    tick = src_en;
      CS_DIV8:    tick = src_en && ((pre_ff & MASK_DIV8) == MASK_DIV8);
      CS_DIV32:   tick = src_en && ((pre_ff & MASK_DIV32) == MASK_DIV32);
      CS_DIV64:   tick = src_en && ((pre_ff & MASK_DIV64) == MASK_DIV64);
      CS_DIV128:  tick = src_en && ((pre_ff & MASK_DIV128) == MASK_DIV128);
      CS_DIV256:  tick = src_en && ((pre_ff & MASK_DIV256) == MASK_DIV256);
      CS_DIV1024: tick = src_en && ((pre_ff & MASK_DIV1024) == MASK_DIV1024);
      default:    tick = 1'b0;
    endcase
  end

  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      nxt_temp[i]  = temp_ff[i];
      nxt_edges[i] = edges_ff[i];
      nxt_busy[i]  = update_busy_ff[i];
      load[i]      = 1'b0;
      load_val[i]  = temp_ff[i];
      if (!async_clock_sel) begin
        load[i]     = reg_wr_strobe[i];
        load_val[i] = reg_wr_data;
        nxt_busy[i] = 1'b0;
      end else if (reg_wr_strobe[i]) begin
        nxt_temp[i]  = reg_wr_data;
        nxt_edges[i] = 2'h0;
        nxt_busy[i]  = 1'b1;
      end else if (update_busy_ff[i] && osc_rise) begin
        nxt_edges[i] = edges_ff[i] + 2'h1;
        if (edges_ff[i] + 2'h1 == LATCH_EDGES) begin
          load[i]     = 1'b1;
          nxt_busy[i] = 1'b0;
        end
      end
    end
  end

  always_comb begin
    mode    = {ctrl_b_ff[CB_MODE_HI], ctrl_a_ff[CA_MODE_LSB +: 2]};
    pc_mode = (mode == MODE_PC_FIX) || (mode == MODE_PC_VAR);
    top_val = (mode == MODE_PC_VAR) ? cmp_a_ff : CNT_MAX;
    nxt_cmp_a  = load[REG_CMP_A]  ? load_val[REG_CMP_A]  : cmp_a_ff;
    nxt_cmp_b  = load[REG_CMP_B]  ? load_val[REG_CMP_B]  : cmp_b_ff;
    nxt_ctrl_a = load[REG_CTRL_A] ? load_val[REG_CTRL_A] : ctrl_a_ff;
    nxt_ctrl_b = load[REG_CTRL_B] ? load_val[REG_CTRL_B] : ctrl_b_ff;
    nxt_cnt    = cnt_ff;
    nxt_cnt_up = cnt_up_ff;
    evt        = tick && !load[REG_CNT];
    if (load[REG_CNT]) begin
      nxt_cnt = load_val[REG_CNT];
    end else if (tick && pc_mode) begin
      if (cnt_up_ff) begin
        if (cnt_ff >= top_val && cnt_ff != CNT_BOTTOM) begin
          nxt_cnt    = cnt_ff - CNT_ONE;
          nxt_cnt_up = 1'b0;
        end else begin
          nxt_cnt = cnt_ff + CNT_ONE;
        end
      end else if (cnt_ff == CNT_BOTTOM) begin
        nxt_cnt    = CNT_ONE;
        nxt_cnt_up = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - CNT_ONE;
      end
    end else if (tick) begin
      nxt_cnt    = cnt_ff + CNT_ONE;
      nxt_cnt_up = 1'b1;
    end
    at_top    = evt && pc_mode && cnt_up_ff && nxt_cnt_up && (nxt_cnt == top_val);
    at_bot    = evt && pc_mode && !cnt_up_ff && (nxt_cnt == CNT_BOTTOM);
    inhibit_a = async_clock_sel && (update_busy_ff[REG_CNT] || update_busy_ff[REG_CMP_A]);
    inhibit_b = async_clock_sel && (update_busy_ff[REG_CNT] || update_busy_ff[REG_CMP_B]);
  end

  always_comb begin
    raw_flag[0] = at_bot;
    raw_flag[1] = evt && pc_mode && !inhibit_a && (nxt_cnt == cmp_a_ff);
    raw_flag[2] = evt && pc_mode && !inhibit_b && (nxt_cnt == cmp_b_ff);
    nxt_pipe[0] = raw_flag;
    for (int s = 1; s < FLAG_PIPE; s++) begin
      nxt_pipe[s] = pipe_ff[s-1];
    end
    set_flag = async_clock_sel ? pipe_ff[FLAG_PIPE-1] : raw_flag;
    nxt_ovf  = set_flag[0] | (overflow_flag_ff & ~ovf_clear);
    nxt_cfa  = set_flag[1] | (compare_flag_a_ff & ~cmp_clear_a);
    nxt_cfb  = set_flag[2] | (compare_flag_b_ff & ~cmp_clear_b);
    nxt_wake_arm = async_clock_sel && (wake_arm_ff || (|raw_flag)) && !(wake_arm_ff && src_en);
    nxt_wake     = wake_arm_ff && src_en;
    nxt_read     = async_clock_sel ? (osc_rise ? cnt_ff : counter_read_ff) : cnt_ff;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      osc_q_ff          <= 1'b0;
      osc_prev_ff       <= 1'b0;
      pre_ff            <= PRE_RST;
      cnt_ff            <= REG_RST;
      cmp_a_ff          <= REG_RST;
      cmp_b_ff          <= REG_RST;
      ctrl_a_ff         <= REG_RST;
      ctrl_b_ff         <= REG_RST;
      cnt_up_ff         <= 1'b1;
      update_busy_ff    <= 5'h00;
      overflow_flag_ff  <= 1'b0;
      compare_flag_a_ff <= 1'b0;
      compare_flag_b_ff <= 1'b0;
      wake_arm_ff       <= 1'b0;
      wake_ff           <= 1'b0;
      counter_read_ff   <= REG_RST;
      for (int i = 0; i < NUM_REGS; i++) begin
        temp_ff[i]  <= REG_RST;
        edges_ff[i] <= 2'h0;
      end
      for (int s = 0; s < FLAG_PIPE; s++) begin
        pipe_ff[s] <= 3'h0;
      end
    end else if (clk_en) begin
      osc_q_ff          <= osc_input_pin;
      osc_prev_ff       <= osc_q_ff;
      pre_ff            <= nxt_pre;
      cnt_ff            <= nxt_cnt;
      cmp_a_ff          <= nxt_cmp_a;
      cmp_b_ff          <= nxt_cmp_b;
      ctrl_a_ff         <= nxt_ctrl_a;
      ctrl_b_ff         <= nxt_ctrl_b;
      cnt_up_ff         <= nxt_cnt_up;
      update_busy_ff    <= nxt_busy;
      overflow_flag_ff  <= nxt_ovf;
      compare_flag_a_ff <= nxt_cfa;
      compare_flag_b_ff <= nxt_cfb;
      wake_arm_ff       <= nxt_wake_arm;
      wake_ff           <= nxt_wake;
      counter_read_ff   <= nxt_read;
      for (int i = 0; i < NUM_REGS; i++) begin
        temp_ff[i]  <= nxt_temp[i];
        edges_ff[i] <= nxt_edges[i];
      end
      for (int s = 0; s < FLAG_PIPE; s++) begin
        pipe_ff[s] <= nxt_pipe[s];
      end
    end
  end

  apwm_chan u_chan_a (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .clk_en    (clk_en),
    .evt       (evt && pc_mode),
    .moving_up (cnt_up_ff),
    .new_cnt   (nxt_cnt),
    .cmp       (cmp_a_ff),
    .top       (top_val),
    .action    (ctrl_a_ff[CA_ACT_A_LSB +: 2]),
    .inhibit   (inhibit_a),
    .at_top    (at_top),
    .at_bot    (at_bot),
    .port_data (port_data_a),
    .dir_out   (port_dir_out_a),
    .level_ff  (compare_output_a),
    .pin_ff    (pin_level_a),
    .oe_n_ff   (pin_oe_n_a)
  );

  apwm_chan u_chan_b (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .clk_en    (clk_en),
    .evt       (evt && pc_mode),
    .moving_up (cnt_up_ff),
    .new_cnt   (nxt_cnt),
    .cmp       (cmp_b_ff),
    .top       (top_val),
    .action    (ctrl_a_ff[CA_ACT_B_LSB +: 2]),
    .inhibit   (inhibit_b),
    .at_top    (at_top),
    .at_bot    (at_bot),
    .port_data (port_data_b),
    .dir_out   (port_dir_out_b),
    .level_ff  (compare_output_b),
    .pin_ff    (pin_level_b),
    .oe_n_ff   (pin_oe_n_b)
  );

  a_top_reverse: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && tick && pc_mode && !load[REG_CNT] && cnt_up_ff && cnt_ff == top_val
     && top_val != CNT_BOTTOM) |=> (!cnt_up_ff && cnt_ff == $past(top_val) - CNT_ONE))
    else $error("counter did not turn down after TOP");
  a_bottom_reverse: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && tick && pc_mode && !load[REG_CNT] && !cnt_up_ff && cnt_ff == CNT_BOTTOM)
    |=> (cnt_up_ff && cnt_ff == CNT_ONE))
    else $error("counter did not turn up after BOTTOM");
  a_tick_gate: assert property (@(posedge sys_clk) disable iff (srst)
    (!srst && clk_en && !tick && !load[REG_CNT]) |=> $stable(cnt_ff))
    else $error("counter moved without a tick");
  a_ovf_sync: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && !async_clock_sel && at_bot) |=> overflow_flag_ff)
    else $error("overflow flag missed at BOTTOM");
  a_ovf_async: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && async_clock_sel && at_bot) ##1 (clk_en && async_clock_sel)[*2]
    |=> overflow_flag_ff)
    else $error("async overflow flag not visible after three cycles");
  a_busy_set: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && async_clock_sel && reg_wr_strobe[REG_CMP_A]) |=> update_busy_ff[REG_CMP_A])
    else $error("busy flag not raised on async write");
  a_busy_edge: assert property (@(posedge sys_clk) disable iff (srst)
    (async_clock_sel && $fell(update_busy_ff[REG_CMP_A])) |-> $past(osc_rise))
    else $error("pending write landed without oscillator edge");
  a_read_hold: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && async_clock_sel && !osc_rise) |=> $stable(counter_read_ff))
    else $error("read copy changed between oscillator edges");
  a_flag_set_wins: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && set_flag[0] && ovf_clear) |=> overflow_flag_ff)
    else $error("clear beat a simultaneous overflow");
endmodule : apwm_timer
`default_nettype wire

/* rtl/apwm_pkg.sv */
// Constants for the dual-slope PWM timer with optional oscillator-paced operation
// Operation
// - Modes 1 and 5 select phase-correct PWM
// - Counter sweeps BOTTOM to TOP, then back down
// - TOP is 0xFF or compare value A
// - Counter holds TOP one tick, then reverses
// - Action two: clear up-match, set down-match
// - Action three: set up-match, clear down-match
// - Overflow flag sets when counter reaches BOTTOM in phase-correct modes only
// - Pin driven only when direction is output
// - BOTTOM compare constant low, MAX constant high for action two, opposite for action three
// - TOP level follows up-match result after MAX
// - Missed up-match change still happens at TOP
// - One period spans 510 prescaled ticks when TOP is 0xFF
// - Prescaled tick is a clock enable only
// - Async writes latch after two oscillator edges
// - Five registers each own a temporary register
// - Busy flag per pending write, clears when done
// - Compare match disabled during async value writes
// - Counter read copy refreshed each oscillator edge
// - Wake-up starts on following timer clock
// - Async flag sync takes three CPU cycles
// - Compare output changes on timer clock only
// - Oscillator stops in power-down and standby
// - Action zero leaves pin to port control
`default_nettype none
package apwm_pkg;
  localparam logic [7:0] CNT_BOTTOM   = 8'h00;
  localparam logic [7:0] CNT_MAX      = 8'hFF;
  localparam logic [7:0] CNT_ONE      = 8'h01;
  localparam logic [2:0] MODE_PC_FIX  = 3'h1;
  localparam logic [2:0] MODE_PC_VAR  = 3'h5;
  localparam logic [1:0] ACT_OFF      = 2'h0;
  localparam logic [1:0] ACT_NONINV   = 2'h2;
  localparam logic [1:0] ACT_INV      = 2'h3;
  localparam int         PERIOD_TICKS = 510;
  // Clock select codes
  localparam logic [2:0] CS_STOP      = 3'h0;
  localparam logic [2:0] CS_DIV1      = 3'h1;
  localparam logic [2:0] CS_DIV8      = 3'h2;
  localparam logic [2:0] CS_DIV32     = 3'h3;
  localparam logic [2:0] CS_DIV64     = 3'h4;
  localparam logic [2:0] CS_DIV128    = 3'h5;
  localparam logic [2:0] CS_DIV256    = 3'h6;
  localparam logic [2:0] CS_DIV1024   = 3'h7;
  localparam logic [9:0] MASK_DIV8    = 10'h007;
  localparam logic [9:0] MASK_DIV32   = 10'h01F;
  localparam logic [9:0] MASK_DIV64   = 10'h03F;
  localparam logic [9:0] MASK_DIV128  = 10'h07F;
  localparam logic [9:0] MASK_DIV256  = 10'h0FF;
  localparam logic [9:0] MASK_DIV1024 = 10'h3FF;
  localparam logic [9:0] PRE_RST      = 10'h000;
  // Write strobe indices
  localparam int         NUM_REGS     = 5;
  localparam int         REG_CNT      = 0;
  localparam int         REG_CMP_A    = 1;
  localparam int         REG_CMP_B    = 2;
  localparam int         REG_CTRL_A   = 3;
  localparam int         REG_CTRL_B   = 4;
  localparam logic [7:0] REG_RST      = 8'h00;
  // Control field positions
  localparam int         CA_ACT_A_LSB = 6;
  localparam int         CA_ACT_B_LSB = 4;
  localparam int         CA_MODE_LSB  = 0;
  localparam int         CB_MODE_HI   = 3;
  localparam int         CB_CS_LSB    = 0;
  // Oscillator edges before a pending write lands
  localparam logic [1:0] LATCH_EDGES  = 2'h2;
  // Cycles for an async flag event to reach the visible flag
  localparam int         FLAG_SYNC_CYC = 3;
  localparam int         FLAG_PIPE     = FLAG_SYNC_CYC - 1;
endpackage : apwm_pkg
`default_nettype wire

/* rtl/apwm_chan.sv */
// One compare output channel of the dual-slope PWM timer
`timescale 1ns/10ps
`default_nettype none
module apwm_chan
  import apwm_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       clk_en,
  input  wire logic       evt,
  input  wire logic       moving_up,
  input  wire logic [7:0] new_cnt,
  input  wire logic [7:0] cmp,
  input  wire logic [7:0] top,
  input  wire logic [1:0] action,
  input  wire logic       inhibit,
  input  wire logic       at_top,
  input  wire logic       at_bot,
  input  wire logic       port_data,
  input  wire logic       dir_out,
  output logic            level_ff,
  output logic            pin_ff,
  output logic            oe_n_ff
);
  logic nxt_level;
  logic nxt_pin;
  logic nxt_oe_n;
  logic up_res;
  logic connected;

  always_comb begin
    up_res    = (action == ACT_INV);
    connected = action[1];
    nxt_level = level_ff;
    if (connected) begin
      if (at_bot) begin
        nxt_level = (cmp == CNT_BOTTOM) ? up_res : ~up_res;
      end else if (at_top) begin
        nxt_level = (cmp >= top) ? ~up_res : up_res;
      end else if (evt && !inhibit && new_cnt == cmp) begin
        nxt_level = moving_up ? up_res : ~up_res;
      end
    end
    nxt_pin  = connected ? nxt_level : port_data;
    nxt_oe_n = ~dir_out;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      level_ff <= 1'b0;
      pin_ff   <= 1'b0;
      oe_n_ff  <= 1'b1;
    end else if (clk_en) begin
      level_ff <= nxt_level;
      pin_ff   <= nxt_pin;
      oe_n_ff  <= nxt_oe_n;
    end
  end

  a_noninv_up_clear: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && action == ACT_NONINV && evt && !inhibit && moving_up && !at_top && !at_bot
     && new_cnt == cmp) |=> !level_ff)
    else $error("non-inverting up match did not clear output");
  a_inv_down_clear: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && action == ACT_INV && evt && !inhibit && !moving_up && !at_top && !at_bot
     && new_cnt == cmp) |=> !level_ff)
    else $error("inverting down match did not clear output");
  a_bottom_low: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && action == ACT_NONINV && at_bot && cmp == CNT_BOTTOM) |=> !level_ff)
    else $error("zero compare did not hold output low");
  a_pin_dir: assert property (@(posedge sys_clk) disable iff (srst)
    (!srst && clk_en) |=> (oe_n_ff == !$past(dir_out)))
    else $error("pin drive does not follow direction");
  a_off_port: assert property (@(posedge sys_clk) disable iff (srst)
    (!srst && clk_en && action == ACT_OFF) |=> (pin_ff == $past(port_data)))
    else $error("disconnected channel did not pass port data");
endmodule : apwm_chan
`default_nettype wire

/* verif/apwm_osc_model.sv */
// Free-running oscillator model that stops while the device is powered down
`timescale 1ns/10ps
`default_nettype none
module apwm_osc_model #(
  parameter int HALF_NS = 160
) (
  input  wire logic run,
  output logic      osc
);
  initial begin
    osc = 1'b0;
    // Offset keeps oscillator edges away from system clock edges
    #5;
    forever begin
      #(HALF_NS);
      if (run) begin
        osc = ~osc;
      end
    end
  end
endmodule // apwm_osc_model
`default_nettype wire

/* verif/apwm_timer_tb.sv */
// Self-checking bench for the dual-slope PWM timer
`timescale 1ns/10ps
`default_nettype none
module apwm_timer_tb
  import apwm_pkg::*;
;
  logic sys_clk, srst, asel, osc, pdn, oclr, cca, ccb, pda, pdb, dra, drb;
  logic [4:0] strb;
  logic [7:0] wdat, counter_read_ff;
  logic [4:0] update_busy_ff;
  logic overflow_flag_ff, compare_flag_a_ff, compare_flag_b_ff, wake_ff;
  logic compare_output_a, compare_output_b, pin_level_a, pin_level_b, pin_oe_n_a, pin_oe_n_b;
  logic [15:0] ha, hb, ov, cf, nt, mx, v, fb, pa;
  int bad_count, checked, g;
  logic po, cen;

  apwm_timer i_dut (.sys_clk(sys_clk), .srst(srst), .clk_en(cen), .async_clock_sel(asel),
    .osc_input_pin(osc), .power_down(pdn), .reg_wr_strobe(strb), .reg_wr_data(wdat),
    .ovf_clear(oclr), .cmp_clear_a(cca), .cmp_clear_b(ccb), .port_data_a(pda),
    .port_data_b(pdb), .port_dir_out_a(dra), .port_dir_out_b(drb),
    .counter_read_ff(counter_read_ff), .update_busy_ff(update_busy_ff),
    .overflow_flag_ff(overflow_flag_ff), .compare_flag_a_ff(compare_flag_a_ff),
    .compare_flag_b_ff(compare_flag_b_ff), .wake_ff(wake_ff),
    .compare_output_a(compare_output_a), .compare_output_b(compare_output_b),
    .pin_level_a(pin_level_a), .pin_level_b(pin_level_b),
    .pin_oe_n_a(pin_oe_n_a), .pin_oe_n_b(pin_oe_n_b));

  apwm_osc_model #(.HALF_NS(160)) i_osc (.run(~pdn), .osc(osc));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input int idx, input logic [7:0] d);
    @(posedge sys_clk);
    strb <= 5'(1 << idx);
    wdat <= d;
    @(posedge sys_clk);
    strb <= 5'h00;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Counter advance over two prescaler periods in the plain counting mode
  task automatic div_chk(input logic [2:0] cs, input int n);
    wr(REG_CTRL_B, {5'h00, cs});
    settle(4);
    #1 v = 16'(counter_read_ff);
    settle(2 * n);
    #1 chk(16'(8'(counter_read_ff - v[7:0])), 16'h0002);
  endtask

  task automatic wait_idle;
    g = 0;
    #1;
    while (update_busy_ff !== 5'h00 && g < 2000) begin
      @(posedge sys_clk);
      #1;
      g++;
    end
    if (g >= 2000) bad_count++;
  endtask

  // Counts output highs, flag cycles and counter peaks over a window
  task automatic run_win(input int n);
    ha = 0; hb = 0; ov = 0; cf = 0; nt = 0; mx = 0;
    fb = 0;
    pa = 0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      ha += 16'(compare_output_a === 1'b1);
      hb += 16'(compare_output_b === 1'b1);
      ov += 16'(overflow_flag_ff === 1'b1);
      cf += 16'(compare_flag_a_ff === 1'b1);
      fb += 16'(compare_flag_b_ff === 1'b1);
      pa += 16'(pin_level_a === 1'b1);
      nt += 16'(counter_read_ff === 8'hFF);
      if (counter_read_ff > mx[7:0]) mx = 16'(counter_read_ff);
    end
  endtask

  initial begin
    #800_000;
    bad_count++;
    complete_run();
  end

  initial begin
    srst = 1'b1; asel = 1'b0; pdn = 1'b0; oclr = 1'b1; cca = 1'b1; ccb = 1'b1;
    pda = 1'b0; pdb = 1'b0; dra = 1'b1; drb = 1'b0; strb = 5'h00; wdat = 8'h00;
    cen = 1'b1;
    bad_count = 0; checked = 0;
    settle(4);
    srst <= 1'b0;
    wr(REG_CMP_A, 8'h80);
    wr(REG_CMP_B, 8'h40);
    wr(REG_CTRL_A, 8'hB1);
    wr(REG_CTRL_B, 8'h01);
    #1 chk(16'(update_busy_ff), 16'h0000);
    settle(600);
    run_win(510);
    chk(ha, 16'd256);
    chk(hb, 16'd382);
    chk(ov, 16'd1);
    chk(cf, 16'd2);
    chk(mx, 16'h00FF);
    chk(nt, 16'd1);
    chk(pa, 16'd256);
    chk(fb, 16'd2);
    chk(16'(pin_oe_n_a), 16'h0000);
    chk(16'(pin_oe_n_b), 16'h0001);
    @(posedge sys_clk);
    oclr <= 1'b0;
    settle(600);
    #1 chk(16'(overflow_flag_ff), 16'h0001);
    @(posedge sys_clk);
    oclr <= 1'b1;
    cen <= 1'b0;
    settle(2);
    #1 v = 16'(counter_read_ff);
    settle(20);
    #1 chk(16'(counter_read_ff), v);
    @(posedge sys_clk);
    cen <= 1'b1;
    wr(REG_CMP_A, 8'h00);
    wr(REG_CMP_B, 8'hFF);
    settle(600);
    run_win(510);
    chk(ha, 16'd0);
    chk(hb, 16'd0);
    wr(REG_CMP_A, 8'hFF);
    wr(REG_CMP_B, 8'h00);
    settle(600);
    run_win(510);
    chk(ha, 16'd510);
    chk(hb, 16'd510);
    wr(REG_CMP_A, 8'hC0);
    settle(600);
    run_win(510);
    chk(ha, 16'd384);
    wr(REG_CMP_A, 8'h64);
    wr(REG_CTRL_B, 8'h09);
    settle(600);
    run_win(400);
    chk(mx, 16'h0064);
    chk(ov, 16'd2);
    wr(REG_CTRL_A, 8'hB0);
    wr(REG_CTRL_B, 8'h01);
    settle(600);
    run_win(512);
    chk(nt, 16'd2);
    chk(ov, 16'd0);
    div_chk(CS_DIV8, 8);
    div_chk(CS_DIV32, 32);
    div_chk(CS_DIV64, 64);
    div_chk(CS_DIV128, 128);
    div_chk(CS_DIV256, 256);
    div_chk(CS_DIV1024, 1024);
    wr(REG_CTRL_A, 8'h31);
    pda <= 1'b1;
    settle(3);
    #1 chk(16'(pin_level_a), 16'h0001);
    @(posedge sys_clk);
    pda <= 1'b0;
    settle(3);
    #1 chk(16'(pin_level_a), 16'h0000);
    @(posedge sys_clk);
    asel <= 1'b1;
    wr(REG_CTRL_B, 8'h00);
    wait_idle();
    wr(REG_CNT, 8'h5A);
    wr(REG_CMP_B, 8'h40);
    #1 chk(16'(update_busy_ff), 16'h0005);
    wait_idle();
    chk(16'(update_busy_ff), 16'h0000);
    repeat (3) @(posedge osc);
    settle(4);
    #1 chk(16'(counter_read_ff), 16'h005A);
    @(posedge osc);
    settle(4);
    wr(REG_CMP_A, 8'h80);
    v = 0; g = 0; po = osc;
    #1;
    while (update_busy_ff[1] === 1'b1 && g < 200) begin
      @(posedge sys_clk);
      #1;
      if (osc && !po) v++;
      po = osc;
      g++;
    end
    if (g >= 200) bad_count++;
    chk(v, 16'd2);
    wr(REG_CTRL_B, 8'h01);
    wait_idle();
    @(posedge sys_clk);
    pdn <= 1'b1;
    settle(20);
    #1 v = 16'(counter_read_ff);
    settle(100);
    #1 chk(16'(counter_read_ff), v);
    @(posedge sys_clk);
    pdn <= 1'b0;
    g = 0;
    #1;
    while (wake_ff !== 1'b1 && g < 20000) begin
      @(posedge sys_clk);
      #1;
      g++;
    end
    chk(16'(wake_ff), 16'h0001);
    complete_run();
  end
endmodule // apwm_timer_tb
`default_nettype wire
